// [include/reset_cause_pkg.sv]
// Constants, types and register map of the reset-cause recorder.
// Assumes a single 50 MHz system clock and a plain register port.
package reset_cause_pkg;

   localparam int          PC_W          = 15;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 8;

   // Resume addresses
   localparam logic [14:0] RESET_VECTOR  = 15'h0000;
   localparam logic [14:0] INT_VECTOR    = 15'h0004;

   // Register offsets
   localparam logic [3:0]  ADR_CAUSE     = 4'h0;
   localparam logic [3:0]  ADR_STATE     = 4'h1;
   localparam logic [3:0]  ADR_CTRL      = 4'h2;
   localparam logic [3:0]  ADR_IRQ_STAT  = 4'h3;
   localparam logic [3:0]  ADR_IRQ_EN    = 4'h4;
   localparam logic [3:0]  ADR_IRQ_CLR   = 4'h5;

   // Cause register fields; bits 5 and 0 are unimplemented
   localparam int          B_STK_OVF     = 7;
   localparam int          B_STK_UNF     = 6;
   localparam int          B_PIN_RST     = 4;
   localparam int          B_RST_INSTR   = 3;
   localparam int          B_POWER_ON    = 2;
   localparam int          B_BROWNOUT    = 1;
   // State register fields
   localparam int          B_TIMEOUT     = 4;
   localparam int          B_POWERDOWN   = 3;
   // Control register field
   localparam int          B_STK_RST_EN  = 0;

   // Reset values
   localparam logic [7:0]  CTRL_RST      = 8'h01;
   localparam logic [7:0]  IRQ_EN_RST    = 8'h00;

   // One-cycle event pulses from the core, in interrupt-bit order
   typedef struct packed {
      logic stackUnf;    // bit 7
      logic stackOvf;    // bit 6
      logic resetInstr;  // bit 5
      logic irqWake;     // bit 4
      logic wdtExpire;   // bit 3
      logic pinReset;    // bit 2
      logic brownout;    // bit 1
      logic powerOn;     // bit 0
   } evt_t;

   // Cause flags as software sees them
   typedef struct packed {
      logic stack_overflow_flag;
      logic stack_underflow_flag;
      logic external_pin_reset_flag;
      logic reset_instruction_flag;
      logic powerOnFlag;
      logic brownout_flag;
      logic timeout_flag;
      logic powerdown_flag;
   } flags_t;

   // Power-on values of the flags; brown-out is unknown, held at 0
   localparam flags_t FLAGS_POR = '{
      stack_overflow_flag: 1'b0, stack_underflow_flag: 1'b0,
      external_pin_reset_flag: 1'b1, reset_instruction_flag: 1'b1,
      powerOnFlag: 1'b0, brownout_flag: 1'b0,
      timeout_flag: 1'b1, powerdown_flag: 1'b1};

   typedef enum logic [1:0] {
      RES_VECTOR,
      RES_NEXT,
      RES_INTVEC
   } resume_t;

   typedef enum logic {
      ST_IDLE,
      ST_EXEC_NEXT
   } seq_t;

endpackage : reset_cause_pkg

// [testbench/reset_cause_recorder_monitor.sv]
// Port checker for the reset-cause recorder, bound to every instance.
// Assumes one clock domain, clk_sys, with asynchronous arst_n.
`timescale 1ns/100ps

module reset_cause_recorder_monitor (
   input wire logic                     clk_sys,
   input wire logic                     arst_n,
   input wire logic                     clkEn,
   input wire reset_cause_pkg::evt_t    evtIn,
   input wire logic                     external_reset_pin_n,
   input wire logic                     sleeping,
   input wire logic                     global_interrupt_enable,
   input wire logic [14:0]              pcNow,
   input wire logic                     instrDone,
   input wire logic [3:0]               regAddr,
   input wire logic [7:0]               regWdata,
   input wire logic                     regWr,
   input wire logic                     regRd,
   input wire logic [7:0]               regRdata,
   input wire reset_cause_pkg::flags_t  flagsOut,
   input wire logic                     resumeValid,
   input wire reset_cause_pkg::resume_t resumeKind,
   input wire logic [14:0]              resumeAddr,
   input wire logic                     pushValid,
   input wire logic [14:0]              pushAddr,
   input wire logic                     irq
);
   import reset_cause_pkg::*;
   logic       stkEn_ff;
   logic       nxt_stkEn;
   logic       hiA;
   logic       hiB;
   logic [7:0] causeView;
   logic [7:0] stateView;

   // Shadow of the stack reset enable, tracked from register writes
   always_comb begin
      nxt_stkEn = stkEn_ff;
      if (clkEn && regWr && regAddr == ADR_CTRL) begin
         nxt_stkEn = regWdata[B_STK_RST_EN];
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stkEn_ff <= CTRL_RST[0];
      end else begin
         stkEn_ff <= nxt_stkEn;
      end
   end

   // Higher-priority events that mask a lower one
   assign hiA = evtIn.powerOn | evtIn.brownout | evtIn.pinReset;
   assign hiB = hiA | evtIn.wdtExpire;
   assign causeView = {flagsOut[7:6], 1'b0, flagsOut[5:2], 1'b0};
   assign stateView = {3'b000, flagsOut[1:0], 3'b000};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_por_release: assert property ($rose(arst_n) |->
      flagsOut == FLAGS_POR)
      else $error("flags not at power-on pattern after reset");
   a_poweron_event: assert property (clkEn && evtIn.powerOn |=>
      flagsOut == FLAGS_POR && resumeValid && resumeAddr == RESET_VECTOR)
      else $error("power-on event did not restore flags");
   a_brownout_event: assert property (clkEn && evtIn.brownout &&
      !evtIn.powerOn |=> !flagsOut.brownout_flag && flagsOut.timeout_flag
      && flagsOut.powerdown_flag && resumeAddr == RESET_VECTOR)
      else $error("brown-out flags or restart wrong");
   a_pin_event: assert property (clkEn && evtIn.pinReset && !evtIn.powerOn
      && !evtIn.brownout |=> !flagsOut.external_pin_reset_flag
      && resumeValid && resumeKind == RES_VECTOR)
      else $error("pin reset not recorded");
   a_wdt_sleep: assert property (clkEn && evtIn.wdtExpire && sleeping &&
      !hiA |=> !flagsOut.timeout_flag && !flagsOut.powerdown_flag &&
      resumeKind == RES_NEXT && resumeAddr == $past(pcNow) + 15'h0001)
      else $error("watchdog wake did not resume at next address");
   a_irq_wake: assert property (clkEn && sleeping && evtIn == 8'h10 |=>
      flagsOut.timeout_flag && !flagsOut.powerdown_flag && resumeValid
      && resumeKind == RES_NEXT && resumeAddr == $past(pcNow) + 15'h0001)
      else $error("interrupt wake flags or resume wrong");
   a_stack_ovf: assert property (clkEn && stkEn_ff && evtIn.stackOvf &&
      !hiB |=> flagsOut.stack_overflow_flag && resumeKind == RES_VECTOR)
      else $error("stack overflow not recorded");
   a_stack_unf: assert property (clkEn && stkEn_ff && evtIn.stackUnf &&
      !evtIn.stackOvf && !hiB |=> flagsOut.stack_underflow_flag
      && resumeKind == RES_VECTOR)
      else $error("stack underflow not recorded");
   a_int_vector: assert property (pushValid |-> resumeValid &&
      resumeKind == RES_INTVEC && resumeAddr == INT_VECTOR &&
      $past(instrDone) && pushAddr == $past(pcNow))
      else $error("interrupt vector or pushed address wrong");
   a_unmapped_zero: assert property (clkEn && regRd &&
      regAddr > ADR_IRQ_CLR |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_cause_read: assert property (clkEn && regRd && regAddr == ADR_CAUSE
      |=> regRdata == $past(causeView))
      else $error("cause read does not match flags");
   a_state_read: assert property (clkEn && regRd && regAddr == ADR_STATE
      |=> regRdata == $past(stateView))
      else $error("state read does not match flags");
   a_instr_event: assert property (clkEn && evtIn == 8'h20 |=>
      !flagsOut.reset_instruction_flag && resumeAddr == RESET_VECTOR)
      else $error("reset instruction not recorded");
   a_freeze_hold: assert property (!clkEn |=> $stable(flagsOut))
      else $error("flags moved while clock enable low");
   a_irq_release: assert property ($fell(irq) |->
      $past(regWr) || $past(regWr, 2))
      else $error("interrupt dropped without a register write");
endmodule : reset_cause_recorder_monitor

bind reset_cause_recorder reset_cause_recorder_monitor mon (
   .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .evtIn(evtIn),
   .external_reset_pin_n(external_reset_pin_n), .sleeping(sleeping),
   .global_interrupt_enable(global_interrupt_enable), .pcNow(pcNow),
   .instrDone(instrDone), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .flagsOut(flagsOut), .resumeValid(resumeValid),
   .resumeKind(resumeKind), .resumeAddr(resumeAddr),
   .pushValid(pushValid), .pushAddr(pushAddr), .irq(irq));

// [testbench/tb.sv]
// Self-checking bench for the reset-cause recorder: flag model, queued
// expectations for reads, resumes and pushes.
// Assumes the package register map and one-cycle event pulses.
`timescale 1ns/100ps

module tb;
   import reset_cause_pkg::*;
   localparam logic [31:0] VEC  = {15'h0, RES_VECTOR, RESET_VECTOR};
   localparam logic [31:0] NONE = '1;
   logic        clk_sys = 0, arst_n = 0, clkEn = 1, sleeping = 0;
   logic        external_reset_pin_n = 1, global_interrupt_enable = 1;
   logic        instrDone = 0, regWr = 0, regRd = 0, rdSeen = 0;
   logic        resumeValid, pushValid, irq;
   evt_t        evtIn = '0;
   flags_t      flagsOut, fm;
   resume_t     resumeKind;
   logic [14:0] pcNow = '0, pc = '0, resumeAddr, pushAddr;
   logic [3:0]  regAddr = '0;
   logic [7:0]  regWdata = '0, regRdata, w;
   logic [31:0] expQ[$], resQ[$], pushQ[$];
   int          error_cnt = 0, samples_checked = 0, cyc = 0;

   reset_cause_recorder dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .clkEn(clkEn), .evtIn(evtIn), .sleeping(sleeping),
      .external_reset_pin_n(external_reset_pin_n), .pcNow(pcNow),
      .global_interrupt_enable(global_interrupt_enable),
      .instrDone(instrDone), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .flagsOut(flagsOut), .resumeValid(resumeValid),
      .resumeKind(resumeKind), .resumeAddr(resumeAddr),
      .pushValid(pushValid), .pushAddr(pushAddr), .irq(irq));

   // 50 MHz system clock
   always #10 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   // Result watcher: pops the oldest note when an output appears
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (rdSeen)
         chk({24'h0, regRdata},
             expQ.size() ? expQ.pop_front() : NONE);
      // Unknown strobes are checked too, so they cannot slip past
      if (resumeValid !== 1'b0)
         chk({15'h0, resumeKind, resumeAddr},
             resQ.size() ? resQ.pop_front() : NONE);
      if (pushValid !== 1'b0)
         chk({17'h0, pushAddr},
             pushQ.size() ? pushQ.pop_front() : NONE);
      rdSeen <= regRd && clkEn;
      if (cyc == 4000) begin
         error_cnt++;
         results();
      end
   end

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      expQ.push_back({24'h0, e});
      @(posedge clk_sys); regAddr <= a; regRd <= 1;
      @(posedge clk_sys); regRd <= 0;
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys); regAddr <= a; regWdata <= d; regWr <= 1;
      @(posedge clk_sys); regWr <= 0;
   endtask : wr

   // Pulse one event; r is the resume it should cause, or NONE
   task automatic ev(input logic [7:0] e, input logic [31:0] r);
      if (r !== NONE) resQ.push_back(r);
      @(posedge clk_sys); evtIn <= evt_t'(e); pcNow <= pc;
      @(posedge clk_sys); evtIn <= '0;
      repeat (2) @(posedge clk_sys);
   endtask : ev

   task automatic step();
      @(posedge clk_sys); instrDone <= 1; pcNow <= pc;
      @(posedge clk_sys); instrDone <= 0;
      repeat (2) @(posedge clk_sys);
   endtask : step

   task automatic chkRegs();
      rd(ADR_CAUSE, {fm[7:6], 1'b0, fm[5:2], 1'b0});
      rd(ADR_STATE, {3'b000, fm[1:0], 3'b000});
   endtask : chkRegs

   task automatic irqIs(input logic e);
      @(negedge clk_sys);
      chk({31'h0, irq}, {31'h0, e});
   endtask : irqIs

   function automatic logic [31:0] nx(input logic [14:0] p);
      return {15'h0, RES_NEXT, p + 15'h0001};
   endfunction : nx

   // Main sequence
   initial begin
      void'($urandom(23));
      fm = FLAGS_POR;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1;
      chkRegs();
      rd(ADR_CTRL, 8'h01);
      rd(ADR_IRQ_EN, 8'h00);
      rd(4'hB, 8'h00);
      $display("test reset done");
      fm.timeout_flag = 0;
      ev(8'h08, VEC);
      ev(8'h10, NONE);
      chkRegs();
      fm.external_pin_reset_flag = 0;
      resQ.push_back(VEC);
      @(posedge clk_sys); external_reset_pin_n <= 0;
      repeat (6) @(posedge clk_sys);
      external_reset_pin_n <= 1;
      repeat (4) @(posedge clk_sys);
      chkRegs();
      fm = flags_t'({4'b0011, fm.powerOnFlag, 3'b011});
      ev(8'h02, VEC);
      chkRegs();
      sleeping <= 1;
      fm.external_pin_reset_flag = 0;
      fm.powerdown_flag = 0;
      ev(8'h04, VEC);
      chkRegs();
      $display("test pin and brownout done");
      pc = 15'($urandom_range(32766, 0));
      fm.timeout_flag = 0;
      ev(8'h08, nx(pc));
      chkRegs();
      global_interrupt_enable <= 0;
      fm.timeout_flag = 1;
      pc = 15'($urandom_range(32766, 0));
      ev(8'h10, nx(pc));
      step();
      global_interrupt_enable <= 1;
      pc = 15'($urandom_range(32766, 0));
      ev(8'h10, nx(pc));
      pc = 15'($urandom_range(32766, 0));
      resQ.push_back({15'h0, RES_INTVEC, INT_VECTOR});
      pushQ.push_back({17'h0, pc});
      step();
      sleeping <= 0;
      chkRegs();
      $display("test wake done");
      wr(ADR_CTRL, 8'h00);
      ev(8'h40, NONE);
      chkRegs();
      wr(ADR_CTRL, 8'h01);
      fm.stack_overflow_flag = 1;
      ev(8'h40, VEC);
      fm.stack_underflow_flag = 1;
      ev(8'h80, VEC);
      fm.reset_instruction_flag = 0;
      ev(8'h20, VEC);
      chkRegs();
      w = 8'($urandom);
      wr(ADR_CAUSE, w);
      wr(ADR_STATE, 8'hFF);
      fm = flags_t'({w[7:6], w[4:1], fm[1:0]});
      chkRegs();
      @(posedge clk_sys); clkEn <= 0; evtIn <= evt_t'(8'h08);
      @(posedge clk_sys); evtIn <= '0;
      @(posedge clk_sys); clkEn <= 1;
      chkRegs();
      fm = FLAGS_POR;
      ev(8'h01, VEC);
      chkRegs();
      $display("test stack and cause done");
      wr(ADR_IRQ_CLR, 8'hFF);
      wr(ADR_IRQ_EN, 8'h08);
      ev(8'h08, VEC);
      irqIs(1'b1);
      rd(ADR_IRQ_STAT, 8'h08);
      wr(ADR_IRQ_CLR, 8'h08);
      repeat (2) @(posedge clk_sys);
      irqIs(1'b0);
      wr(ADR_IRQ_EN, 8'h00);
      ev(8'h08, VEC);
      irqIs(1'b0);
      rd(ADR_IRQ_STAT, 8'h08);
      repeat (4) @(posedge clk_sys);
      chk(expQ.size() + resQ.size() + pushQ.size(), 0);
      $display("test interrupt done");
      results();
   end
endmodule : tb

// [verilog/reset_cause_recorder.sv]
// Reset-cause recorder: keeps cause flags, picks the resume address,
// raises an interrupt on recorded events.
// Assumes event pulses come from core logic on clk_sys; the external
// reset pin is asynchronous and is synchronised here.
`timescale 1ns/100ps

module reset_cause_recorder (
   input  wire logic                              clk_sys,
   input  wire logic                              arst_n,
   input  wire logic                              clkEn,
   input  wire reset_cause_pkg::evt_t             evtIn,
   input  wire logic                              external_reset_pin_n,
   input  wire logic                              sleeping,
   input  wire logic                              global_interrupt_enable,
   input  wire logic [reset_cause_pkg::PC_W-1:0]  pcNow,
   input  wire logic                              instrDone,
   input  wire logic [reset_cause_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [reset_cause_pkg::DATA_W-1:0] regWdata,
   input  wire logic                              regWr,
   input  wire logic                              regRd,
   output logic [reset_cause_pkg::DATA_W-1:0]     regRdata,
   output reset_cause_pkg::flags_t                flagsOut,
   output logic                                   resumeValid,
   output reset_cause_pkg::resume_t               resumeKind,
   output logic [reset_cause_pkg::PC_W-1:0]       resumeAddr,
   output logic                                   pushValid,
   output logic [reset_cause_pkg::PC_W-1:0]       pushAddr,
   output logic                                   irq
);
   import reset_cause_pkg::*;

   // Pin synchroniser and edge detect
   logic          pinSync1_ff;
   logic          pinSync2_ff;
   logic          pinPrev_ff;
   logic          pinFall;

   // Flags, control and interrupt state
   flags_t        flags_ff;
   flags_t        nxt_flags;
   logic [7:0]    ctrl_ff;
   logic [7:0]    nxt_ctrl;
   logic [7:0]    irqStat_ff;
   logic [7:0]    nxt_irqStat;
   logic [7:0]    irqEn_ff;
   logic [7:0]    nxt_irqEn;
   logic          irq_ff;
   logic          nxt_irq;
   logic [7:0]    rdata_ff;
   logic [7:0]    nxt_rdata;

   // Resume sequencer
   seq_t          seq_ff;
   seq_t          nxt_seq;
   logic          resValid_ff;
   logic          nxt_resValid;
   resume_t       resKind_ff;
   resume_t       nxt_resKind;
   logic [14:0]   resAddr_ff;
   logic [14:0]   nxt_resAddr;
   logic          pushValid_ff;
   logic          nxt_pushValid;
   logic [14:0]   pushAddr_ff;
   logic [14:0]   nxt_pushAddr;

   evt_t          evt;
   logic          stkRstEn;
   logic [14:0]   pcNext;

   // Pin is asynchronous; only the second and third stages feed logic
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pinSync1_ff <= 1'b1;
         pinSync2_ff <= 1'b1;
         pinPrev_ff  <= 1'b1;
      end else if (clkEn) begin
         pinSync1_ff <= external_reset_pin_n;
         pinSync2_ff <= pinSync1_ff;
         pinPrev_ff  <= pinSync2_ff;
      end
   end

   assign pinFall  = pinPrev_ff & ~pinSync2_ff;
   assign stkRstEn = ctrl_ff[B_STK_RST_EN];
   assign pcNext   = pcNow + 15'h0001;

   // Qualified events; stack faults count only with reset enable
   always_comb begin
      evt          = evtIn;
      evt.pinReset = evtIn.pinReset | pinFall;
      evt.stackOvf = evtIn.stackOvf & stkRstEn;
      evt.stackUnf = evtIn.stackUnf & stkRstEn;
   end

   // Flag update and resume choice; highest priority event wins
   always_comb begin
      nxt_flags     = flags_ff;
      nxt_seq       = seq_ff;
      nxt_resValid  = 1'b0;
      nxt_resKind   = resKind_ff;
      nxt_resAddr   = resAddr_ff;
      nxt_pushValid = 1'b0;
      nxt_pushAddr  = pushAddr_ff;
      // Software may rewrite flags so the next cause stands out
      if (regWr && regAddr == ADR_CAUSE) begin
         nxt_flags.stack_overflow_flag     = regWdata[B_STK_OVF];
         nxt_flags.stack_underflow_flag    = regWdata[B_STK_UNF];
         nxt_flags.external_pin_reset_flag = regWdata[B_PIN_RST];
         nxt_flags.reset_instruction_flag  = regWdata[B_RST_INSTR];
         nxt_flags.powerOnFlag             = regWdata[B_POWER_ON];
         nxt_flags.brownout_flag           = regWdata[B_BROWNOUT];
      end
      // hardware events override a same-cycle write
      if (evt.powerOn) begin
         nxt_flags    = FLAGS_POR;
         nxt_seq      = ST_IDLE;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_VECTOR;
         nxt_resAddr  = RESET_VECTOR;
      end else if (evt.brownout) begin
         nxt_flags.stack_overflow_flag     = 1'b0;
         nxt_flags.stack_underflow_flag    = 1'b0;
         nxt_flags.external_pin_reset_flag = 1'b1;
         nxt_flags.reset_instruction_flag  = 1'b1;
         nxt_flags.brownout_flag           = 1'b0;
         nxt_flags.timeout_flag            = 1'b1;
         nxt_flags.powerdown_flag          = 1'b1;
         nxt_seq      = ST_IDLE;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_VECTOR;
         nxt_resAddr  = RESET_VECTOR;
      end else if (evt.pinReset) begin
         // pin flag low; when asleep, timeout flag set high and powerdown flag low
         nxt_flags.external_pin_reset_flag = 1'b0;
         if (sleeping) begin
            nxt_flags.timeout_flag   = 1'b1;
            nxt_flags.powerdown_flag = 1'b0;
         end
         nxt_seq      = ST_IDLE;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_VECTOR;
         nxt_resAddr  = RESET_VECTOR;
      end else if (evt.wdtExpire) begin
         // watchdog resets when running, resumes when asleep
         nxt_flags.timeout_flag = 1'b0;
         nxt_resValid = 1'b1;
         if (sleeping) begin
            nxt_flags.powerdown_flag = 1'b0;
            nxt_resKind = RES_NEXT;
            nxt_resAddr = pcNext;
         end else begin
            nxt_seq     = ST_IDLE;
            nxt_resKind = RES_VECTOR;
            nxt_resAddr = RESET_VECTOR;
         end
      end else if (evt.stackOvf || evt.stackUnf) begin
         nxt_flags.stack_overflow_flag  = flags_ff.stack_overflow_flag
                                          | evt.stackOvf;
         nxt_flags.stack_underflow_flag = flags_ff.stack_underflow_flag
                                          | evt.stackUnf;
         nxt_seq      = ST_IDLE;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_VECTOR;
         nxt_resAddr  = RESET_VECTOR;
      end else if (evt.resetInstr) begin
         // instruction reset clears its own flag only
         nxt_flags.reset_instruction_flag = 1'b0;
         nxt_seq      = ST_IDLE;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_VECTOR;
         nxt_resAddr  = RESET_VECTOR;
      end else if (evt.irqWake && sleeping) begin
         // interrupt wake flag pattern and next address
         nxt_flags.timeout_flag   = 1'b1;
         nxt_flags.powerdown_flag = 1'b0;
         nxt_resValid = 1'b1;
         nxt_resKind  = RES_NEXT;
         nxt_resAddr  = pcNext;
         // vector only after the next instruction has run
         if (global_interrupt_enable) begin
            nxt_seq = ST_EXEC_NEXT;
         end
      end else begin
         case (seq_ff)
            ST_IDLE: begin
               nxt_seq = ST_IDLE;
            end
            ST_EXEC_NEXT: begin
               // push return address, load interrupt vector
               if (instrDone) begin
                  nxt_seq       = ST_IDLE;
                  nxt_resValid  = 1'b1;
                  nxt_resKind   = RES_INTVEC;
                  nxt_resAddr   = INT_VECTOR;
                  nxt_pushValid = 1'b1;
                  nxt_pushAddr  = pcNow;
               end
            end
            default: begin
               nxt_seq = ST_IDLE;
            end
         endcase
      end
   end

   // Control, interrupt and read-data next values
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_irqEn   = irqEn_ff;
      nxt_irqStat = irqStat_ff;
      nxt_rdata   = rdata_ff;
      if (regWr && regAddr == ADR_CTRL) begin
         nxt_ctrl = {7'h00, regWdata[B_STK_RST_EN]};
      end else if (regWr && regAddr == ADR_IRQ_EN) begin
         nxt_irqEn = regWdata;
      end else if (regWr && regAddr == ADR_IRQ_CLR) begin
         nxt_irqStat = irqStat_ff & ~regWdata;
      end
      // Set wins over a same-cycle clear
      nxt_irqStat = nxt_irqStat | evt;
      nxt_irq     = |(nxt_irqStat & nxt_irqEn);
      if (regRd) begin
         // unimplemented bits and unmapped offsets read zero
         if (regAddr == ADR_CAUSE) begin
            nxt_rdata = {flags_ff.stack_overflow_flag,
                         flags_ff.stack_underflow_flag, 1'b0,
                         flags_ff.external_pin_reset_flag,
                         flags_ff.reset_instruction_flag,
                         flags_ff.powerOnFlag,
                         flags_ff.brownout_flag, 1'b0};
         end else if (regAddr == ADR_STATE) begin
            nxt_rdata = {3'h0, flags_ff.timeout_flag,
                         flags_ff.powerdown_flag, 3'h0};
         end else if (regAddr == ADR_CTRL) begin
            nxt_rdata = ctrl_ff;
         end else if (regAddr == ADR_IRQ_STAT) begin
            nxt_rdata = irqStat_ff;
         end else if (regAddr == ADR_IRQ_EN) begin
            nxt_rdata = irqEn_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   // State registers; clkEn low freezes everything
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flags_ff     <= FLAGS_POR;
         ctrl_ff      <= CTRL_RST;
         irqStat_ff   <= 8'h00;
         irqEn_ff     <= IRQ_EN_RST;
         irq_ff       <= 1'b0;
         rdata_ff     <= 8'h00;
         seq_ff       <= ST_IDLE;
         resValid_ff  <= 1'b0;
         resKind_ff   <= RES_VECTOR;
         resAddr_ff   <= RESET_VECTOR;
         pushValid_ff <= 1'b0;
         pushAddr_ff  <= 15'h0000;
      end else if (clkEn) begin
         flags_ff     <= nxt_flags;
         ctrl_ff      <= nxt_ctrl;
         irqStat_ff   <= nxt_irqStat;
         irqEn_ff     <= nxt_irqEn;
         irq_ff       <= nxt_irq;
         rdata_ff     <= nxt_rdata;
         seq_ff       <= nxt_seq;
         resValid_ff  <= nxt_resValid;
         resKind_ff   <= nxt_resKind;
         resAddr_ff   <= nxt_resAddr;
         pushValid_ff <= nxt_pushValid;
         pushAddr_ff  <= nxt_pushAddr;
      end
   end

   assign regRdata    = rdata_ff;
   assign flagsOut    = flags_ff;
   assign resumeValid = resValid_ff;
   assign resumeKind  = resKind_ff;
   assign resumeAddr  = resAddr_ff;
   assign pushValid   = pushValid_ff;
   assign pushAddr    = pushAddr_ff;
   assign irq         = irq_ff;

endmodule : reset_cause_recorder
